// ==== btag_pkg.sv ====
// package: constants and carriers for the branch target address generator
package btag_pkg;

  localparam int          BTAG_AW            = 16;
  localparam logic [15:0] BTAG_PC_RESET      = 16'h0000;
  localparam logic [15:0] BTAG_TABLE_BASE    = 16'h0040;
  localparam logic [15:0] BTAG_TABLE_LAST    = 16'h007f;
  localparam int          BTAG_IDX_LSB       = 1;
  localparam int          BTAG_IDX_MSB       = 5;
  localparam int          BTAG_DISP_SIGN     = 7;
  localparam logic [2:0]  BTAG_LEN_ONE       = 3'h1;

  // next-address method chosen by the decoder
  typedef enum logic [4:0] {
    BTAG_SEQ   = 5'b00001,
    BTAG_REL   = 5'b00010,
    BTAG_ABS   = 5'b00100,
    BTAG_TBL   = 5'b01000,
    BTAG_REG   = 5'b10000
  } btag_kind_t;

  // one executed instruction as seen by the generator
  typedef struct packed {
    btag_kind_t  kind;
    logic [2:0]  length;
    logic [7:0]  opcode;
    logic [7:0]  relative_displacement;
    logic [15:0] absolute_target_field;
  } btag_instr_t;

  // table-call handshake towards program memory
  typedef enum logic [2:0] {
    BTAG_IDLE = 3'b001,
    BTAG_LOW  = 3'b010,
    BTAG_HIGH = 3'b100
  } btag_state_t;

endpackage : btag_pkg

// ==== btag_rel_add.sv ====
// relative target adder: sign-extended 8-bit displacement plus next-instruction address
`timescale 1ns/1ps
module btag_rel_add
  import btag_pkg::*;
(
  input  wire logic [15:0] nextAddr,
  input  wire logic [7:0]  displacement,
  output logic      [15:0] target
);
  logic [15:0] extended;
  logic [16:0] fullSum;

  assign extended = {{8{displacement[BTAG_DISP_SIGN]}}, displacement}; // RULE_03
  assign fullSum  = {1'b0, nextAddr} + {1'b0, extended};               // RULE_02
  assign target   = fullSum[15:0];                                      // RULE_11
endmodule : btag_rel_add

// ==== btag_core.sv ====
// branch target address generator: program counter update and direct operand address
`timescale 1ns/1ps
// Notes on behaviour
// RULE_01: without a branch the counter advances by the instruction's byte length.
// RULE_02: relative target is displacement plus address of the following instruction.
// RULE_03: displacement is two's complement, bit 7 sign, sign-extended to 16 bits.
// RULE_04: short unconditional and all conditional branches use relative targets.
// RULE_05: absolute call and branch load the 16-bit immediate into the counter.
// RULE_06: table call takes its index from opcode bits 1 to 5.
// RULE_07: the destination table spans addresses 40H through 7FH.
// RULE_08: register-indirect branch copies the accumulator pair into the counter.
// RULE_09: direct operand address is the 16-bit immediate, unchanged.
// RULE_10: table entries are two bytes from an even address, low byte first.
// RULE_11: carry out of bit 15 is dropped so relative targets wrap.
module btag_core
  import btag_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic        instrValid,
  input  wire btag_instr_t instr,
  input  wire logic        branchTaken,
  input  wire logic [15:0] accumulator_pair,
  input  wire logic        memReady,
  input  wire logic [7:0]  memData,
  output logic      [15:0] program_counter,
  output logic      [15:0] operandAddr,
  output logic             instrReady,
  output logic             memRead,
  output logic      [15:0] memAddr,
  output logic             pcUpdated
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  btag_state_t state_q, state_d;
  logic [15:0] pc_q, pc_d;
  logic [15:0] opAddr_q, opAddr_d;
  logic [15:0] mAddr_q, mAddr_d;
  logic        mRead_q, mRead_d;
  logic [7:0]  lowByte_q, lowByte_d;
  logic        upd_q, upd_d;
  logic        rdy_q, rdy_d;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic        accept;
  logic        isRel;
  logic        isAbs;
  logic        isTbl;
  logic        isReg;
  logic        relJump;
  logic [15:0] nextSeq;
  logic [15:0] relTarget;
  logic [4:0]  tableIndex;
  logic [15:0] tableEntry;
  logic [15:0] tableDest;
  logic [15:0] pcAccept;

  assign accept      = instrValid && (state_q == BTAG_IDLE);
  assign isRel       = (instr.kind == BTAG_REL);
  assign isAbs       = (instr.kind == BTAG_ABS);
  assign isTbl       = (instr.kind == BTAG_TBL);
  assign isReg       = (instr.kind == BTAG_REG);
  // an untaken conditional branch falls through like a plain instruction
  assign relJump     = isRel && branchTaken;                                // RULE_04
  assign nextSeq     = pc_q + {13'h0000, instr.length};                     // RULE_01
  assign tableIndex  = instr.opcode[BTAG_IDX_MSB:BTAG_IDX_LSB];             // RULE_06
  // index times two keeps every entry on an even address inside the table
  assign tableEntry  = BTAG_TABLE_BASE + {10'h000, tableIndex, 1'b0};       // RULE_07 RULE_10

  // ----------------------------------------------------------------
  // target selection
  // ----------------------------------------------------------------
  // low byte was latched first, the high byte is on the bus now
  assign tableDest   = {memData, lowByte_q};                                // RULE_06 RULE_10
  // unknown kinds fall back to a sequential advance rather than a jump
  assign pcAccept    = isAbs   ? instr.absolute_target_field :              // RULE_05
                       isReg   ? accumulator_pair :                         // RULE_08
                       relJump ? relTarget :                                // RULE_02
                                 nextSeq;                                   // RULE_01

  // the adder drops its carry, so relative targets wrap inside the space
  btag_rel_add uRelAdd (
    .nextAddr     (nextSeq),
    .displacement (instr.relative_displacement),
    .target       (relTarget)
  );

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    state_d   = state_q;
    pc_d      = pc_q;
    opAddr_d  = opAddr_q;
    mAddr_d   = mAddr_q;
    mRead_d   = 1'b0;
    lowByte_d = lowByte_q;
    upd_d     = 1'b0;
    case (state_q)
      BTAG_IDLE: begin
        if (accept) begin
          opAddr_d = instr.absolute_target_field;                          // RULE_09
          if (isTbl) begin
            mAddr_d = tableEntry;                                          // RULE_06
            mRead_d = 1'b1;
            state_d = BTAG_LOW;
          end else begin
            pc_d  = pcAccept;
            upd_d = 1'b1;
          end
        end
      end
      BTAG_LOW: begin
        mRead_d = 1'b1;
        if (memReady) begin
          lowByte_d = memData;                                             // RULE_10
          mAddr_d   = mAddr_q + 16'h0001;
          state_d   = BTAG_HIGH;
        end
      end
      BTAG_HIGH: begin
        mRead_d = 1'b1;
        if (memReady) begin
          pc_d    = tableDest;                                             // RULE_06 RULE_10
          mRead_d = 1'b0;
          upd_d   = 1'b1;
          state_d = BTAG_IDLE;
        end
      end
      default: state_d = BTAG_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // registers: state, program counter, operand address and update strobe
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= BTAG_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pc_q <= BTAG_PC_RESET;
    end else begin
      pc_q <= pc_d;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      opAddr_q <= 16'h0000;
    end else begin
      opAddr_q <= opAddr_d;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      upd_q <= 1'b0;
    end else begin
      upd_q <= upd_d;
    end
  end

  // ----------------------------------------------------------------
  // registers: table fetch port
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mAddr_q <= 16'h0000;
    end else begin
      mAddr_q <= mAddr_d;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mRead_q <= 1'b0;
    end else begin
      mRead_q <= mRead_d;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      lowByte_q <= 8'h00;
    end else begin
      lowByte_q <= lowByte_d;
    end
  end

  // ----------------------------------------------------------------
  // registers: instruction handshake
  // ----------------------------------------------------------------
  // ready follows the next state, so it drops for the whole table fetch
  assign rdy_d = (state_d == BTAG_IDLE);
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdy_q <= 1'b1;
    end else begin
      rdy_q <= rdy_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign program_counter = pc_q;
  assign operandAddr     = opAddr_q;
  assign memRead         = mRead_q;
  assign memAddr         = mAddr_q;
  assign pcUpdated       = upd_q;
  assign instrReady      = rdy_q;

endmodule : btag_core

// ==== btag_mem.sv ====
// program memory model answering table byte reads
`timescale 1ns/1ps
module btag_mem
  import btag_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic [1:0]  slow,
  input  wire logic        memRead,
  input  wire logic [15:0] memAddr,
  output logic             memReady,
  output logic [7:0]       memData
);
  logic [1:0] wait_q;
  // idle data is inverted so a stale byte never passes for a fresh one
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      memReady <= 1'b0;
      memData <= 8'h00;
      wait_q <= 2'h0;
    end else if (memRead && !memReady && wait_q == slow) begin
      memReady <= 1'b1;
      memData <= memAddr[7:0] ^ 8'h5a;
      wait_q <= 2'h0;
    end else begin
      memReady <= 1'b0;
      memData <= ~memData;
      wait_q <= (memRead && !memReady) ? wait_q + 2'h1 : 2'h0;
    end
  end
endmodule : btag_mem

// ==== btag_core_assertions.sv ====
// checker for the address generator ports
`timescale 1ns/1ps
module btag_core_chk
  import btag_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        arst_n,
  input wire logic        instrValid,
  input wire btag_instr_t instr,
  input wire logic        branchTaken,
  input wire logic [15:0] accumulator_pair,
  input wire logic        memReady,
  input wire logic [7:0]  memData,
  input wire logic [15:0] program_counter,
  input wire logic [15:0] operandAddr,
  input wire logic        instrReady,
  input wire logic        memRead,
  input wire logic [15:0] memAddr,
  input wire logic        pcUpdated
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  wire tk = instrValid && instrReady;
  wire [15:0] fld = instr.absolute_target_field;
  wire [15:0] nx = program_counter + 16'(instr.length);
  wire [15:0] sx = {{8{instr.relative_displacement[7]}}, instr.relative_displacement};
  wire [15:0] rt = nx + sx;
  logic [7:0] loSeen_q;
  sequence take(k); tk && instr.kind == k; endsequence
  sequence lowByte; memRead && memReady && !memAddr[0]; endsequence
  sequence highByte; memRead && memReady && memAddr[0]; endsequence
  // low table byte as it went by on the bus, to judge the final counter value
  always_ff @(posedge sys_clk) begin
    if (memRead && memReady && !memAddr[0]) begin
      loSeen_q <= memData;
    end
  end
  a_seq_advance: assert property
    (take(BTAG_SEQ) |=> pcUpdated && program_counter == $past(nx)) else $error("seq");
  a_rel_target: assert property
    (take(BTAG_REL) ##0 branchTaken |=> program_counter == $past(rt)) else $error("rel");
  a_rel_fall: assert property
    (take(BTAG_REL) ##0 !branchTaken |=> program_counter == $past(nx)) else $error("rel fall");
  a_abs_load: assert property
    (take(BTAG_ABS) |=> program_counter == $past(fld)) else $error("abs");
  a_reg_load: assert property
    (take(BTAG_REG) |=> program_counter == $past(accumulator_pair)) else $error("reg");
  a_opnd_addr: assert property
    (tk |=> operandAddr == $past(fld)) else $error("opnd");
  a_tbl_start: assert property
    (take(BTAG_TBL) |=> memRead && !instrReady && memAddr == {10'h001, $past(instr.opcode[5:1]), 1'b0})
    else $error("tbl");
  a_tbl_range: assert property
    (memRead |-> memAddr[15:6] == 10'h001) else $error("range");
  a_tbl_pair: assert property
    (lowByte |=> memRead && memAddr == $past(memAddr) + 16'h0001) else $error("pair");
  a_tbl_done: assert property
    (highByte |=> pcUpdated && instrReady && !memRead && program_counter == {$past(memData), loSeen_q})
    else $error("tbl done");
endmodule : btag_core_chk
bind btag_core btag_core_chk u_chk(.sys_clk, .arst_n, .instrValid, .branchTaken, .memReady, .instrReady,
  .memRead, .pcUpdated, .instr, .memData, .accumulator_pair, .program_counter, .operandAddr, .memAddr);

// ==== btag_tb_top.sv ====
// testbench for the address generator
`timescale 1ns/1ps
module btag_tb_top
  import btag_pkg::*;
;
  logic sys_clk = 0, arst_n = 0, instrValid = 0, branchTaken = 0, memReady, memRead, instrReady, pcUpdated;
  logic [15:0] accumulator_pair = 16'h0000, program_counter, operandAddr, memAddr, ex;
  logic [7:0] memData;
  logic [1:0] slow = 2'h0;
  btag_instr_t instr = '0;
  int error_cnt = 0, checks_done = 0;
  btag_core DUT(.sys_clk, .arst_n, .instrValid, .instr, .branchTaken, .accumulator_pair, .memReady,
    .memData, .program_counter, .operandAddr, .instrReady, .memRead, .memAddr, .pcUpdated);
  btag_mem MEM(.sys_clk, .arst_n, .slow, .memRead, .memAddr, .memReady, .memData);
  initial forever #4 sys_clk = ~sys_clk;
  task automatic finish_test;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test
  task automatic chk(string n, logic [15:0] e, logic [15:0] s);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic chk_idle;
    chk("rst pc", 16'h0000, program_counter);
    chk("rst opnd", 16'h0000, operandAddr);
    chk("rst memAddr", 16'h0000, memAddr);
    chk("rst ready", 16'h0001, 16'(instrReady));
    chk("rst memRead", 16'h0000, 16'(memRead));
    chk("rst upd", 16'h0000, 16'(pcUpdated));
  endtask : chk_idle
  task automatic wait_upd;
    int i;
    for (i = 0; i < 40 && pcUpdated !== 1'b1; i++) @(posedge sys_clk) #1;
    if (i == 40) begin
      error_cnt++;
      $display("CHECK FAILED pcUpdated exp 1 got %b", pcUpdated);
      finish_test;
    end
  endtask : wait_upd
  task automatic go(btag_kind_t k, logic [2:0] l, logic [7:0] o, logic [7:0] d, logic [15:0] f);
    @(posedge sys_clk) #1;
    instr = {k, l, o, d, f};
    instrValid = 1;
    @(posedge sys_clk) #1;
    instrValid = 0;
    wait_upd;
    chk("pc", ex, program_counter);
    chk("opnd", f, operandAddr);
  endtask : go
  task automatic t_branch;
    ex = 16'hfff0;
    go(BTAG_ABS, 3'h3, 8'h00, 8'h00, ex);
    branchTaken = 1;
    ex = 16'h0071;
    go(BTAG_REL, 3'h2, 8'h00, 8'h7f, 16'h1234);
    ex = 16'hfff3;
    go(BTAG_REL, 3'h2, 8'h00, 8'h80, 16'h5555);
    branchTaken = 0;
    ex = 16'hfff5;
    go(BTAG_REL, 3'h2, 8'h00, 8'h80, 16'haaaa);
    accumulator_pair = 16'hbeef;
    ex = 16'hbeef;
    go(BTAG_REG, 3'h1, 8'h00, 8'h00, 16'h0000);
    for (int n = 1; n < 5; n++) begin
      ex = ex + 16'(n);
      go(BTAG_SEQ, 3'(n), 8'h00, 8'h00, 16'h1230);
    end
  endtask : t_branch
  task automatic t_table;
    logic [7:0] e;
    for (int j = 0; j < 4; j++) begin
      slow = j[1] ? 2'h3 : 2'h0;
      e = j[0] ? 8'h7e : 8'h40;
      ex = {(e + 8'h01) ^ 8'h5a, e ^ 8'h5a};
      go(BTAG_TBL, 3'h1, j[0] ? 8'hff : 8'h80, 8'h00, 16'h0000);
    end
  endtask : t_table
  task automatic t_refuse;
    @(posedge sys_clk) #1;
    slow = 2'h1;
    instr = {BTAG_TBL, 3'h1, 8'h02, 8'h00, 16'h0000};
    instrValid = 1;
    @(posedge sys_clk) #1;
    // an absolute branch held up during the fetch must wait for ready
    instr = {BTAG_ABS, 3'h3, 8'h00, 8'h00, 16'h4321};
    wait_upd;
    chk("tbl pc", {8'h43 ^ 8'h5a, 8'h42 ^ 8'h5a}, program_counter);
    chk("refused opnd", 16'h0000, operandAddr);
    @(posedge sys_clk) #1;
    chk("abs pc", 16'h4321, program_counter);
    instr = {BTAG_SEQ, 3'h2, 8'h00, 8'h00, 16'h0000};
    @(posedge sys_clk) #1;
    instrValid = 0;
    chk("b2b pc", 16'h4323, program_counter);
    chk("b2b upd", 16'h0001, 16'(pcUpdated));
  endtask : t_refuse
  task automatic t_reset;
    @(posedge sys_clk) #1;
    slow = 2'h3;
    instr = {BTAG_TBL, 3'h1, 8'h04, 8'h00, 16'h0000};
    instrValid = 1;
    @(posedge sys_clk) #1;
    instrValid = 0;
    @(posedge sys_clk) #1;
    chk("fetch memRead", 16'h0001, 16'(memRead));
    chk("fetch ready", 16'h0000, 16'(instrReady));
    chk("fetch memAddr", 16'h0044, memAddr);
    arst_n = 0;
    repeat (3) @(posedge sys_clk);
    #1 chk_idle;
    arst_n = 1;
    chk_idle;
    ex = 16'h0100;
    go(BTAG_ABS, 3'h3, 8'h00, 8'h00, ex);
  endtask : t_reset
  initial begin
    repeat (20) @(posedge sys_clk);
    #1 arst_n = 1;
    chk_idle;
    t_branch;
    t_table;
    t_refuse;
    t_reset;
    finish_test;
  end
endmodule : btag_tb_top
